// ===== tb/mss_contactor_model.sv
// Shorting contactor wired to the end-of-start relay
`timescale 1ns/100ps
`default_nettype none
module mss_contactor_model #(
    parameter int CLOSE_DLY = 6
) (
    input wire logic clk_i,
    input wire mss_pkg::mss_outs_t outs_i,
    output logic shorting_closed_o
);
    import mss_pkg::*;
    int pull_cnt = 0;
    // Coil follows the relay, so a stop drops the contactor at once
    always @(posedge clk_i) begin
        if (!outs_i.end_of_start_relay) begin
            pull_cnt <= 0;
        end else if (pull_cnt < CLOSE_DLY) begin
            pull_cnt <= pull_cnt + 1;
        end
    end
    // Armature travel kept just inside the bypass window
    assign shorting_closed_o = outs_i.end_of_start_relay && pull_cnt == CLOSE_DLY;
endmodule
`default_nettype wire

// ===== tb/mss_io_assertions.sv
// Concurrent checks on the ports of the starter signalling block
`timescale 1ns/100ps
`default_nettype none
module mss_io_checker #(
    parameter longint OC_DELAY_CYC = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire mss_pkg::mss_core_t core_i,
    input wire mss_pkg::mss_meas_t meas_i,
    input wire logic logic_input_i,
    input wire logic keypad_present_i,
    input wire mss_pkg::mss_outs_t outs_o,
    input wire mss_pkg::mss_req_t req_o,
    input wire mss_pkg::mss_preset_t preset_o,
    input wire logic display_blank_o
);
    import mss_pkg::*;
    longint run_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Length of the present over-trip run; a dip restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i || !core_i.over_trip) begin
            run_q <= 0;
        end else begin
            run_q <= run_q + 1;
        end
    end
    property p_reset_outs; disable iff (1'b0) rst_i |=> outs_o == '0 && req_o == '0; endproperty
    a_reset_outs: assert property (p_reset_outs) else $error("outputs not cleared by reset");
    property p_fault_drop; core_i.fault |=> !outs_o.fault_isolation_relay; endproperty
    a_fault_drop: assert property (p_fault_drop) else $error("relay held through fault");
    property p_relay_rise; $rose(outs_o.fault_isolation_relay) |-> !$past(core_i.fault)
        && ($past(core_i.diag_done) || $past(core_i.run_cmd)); endproperty
    a_relay_rise: assert property (p_relay_rise) else $error("relay energised without cause");
    property p_eos_open; core_i.fault || core_i.stop_cmd |=> !outs_o.end_of_start_relay; endproperty
    a_eos_open: assert property (p_eos_open) else $error("run relay not opened");
    property p_eos_close; (core_i.full_speed && !core_i.fault && !core_i.stop_cmd && !req_o.ext_fault
        && !req_o.freewheel_stop) [*2] |=> outs_o.end_of_start_relay; endproperty
    a_eos_close: assert property (p_eos_close) else $error("run relay not closed");
    property p_oc_drop; !core_i.over_trip |=> !outs_o.overcurrent_logic_output; endproperty
    a_oc_drop: assert property (p_oc_drop) else $error("overcurrent output without trip");
    property p_oc_delay; $rose(outs_o.overcurrent_logic_output) |-> run_q >= OC_DELAY_CYC; endproperty
    a_oc_delay: assert property (p_oc_delay) else $error("overcurrent output too early");
    property p_lo1_cause; $rose(outs_o.first_logic_output) |-> $past(core_i.current_present)
        || $past(meas_i.iron_thermal_image) > MSS_IRON_PREALARM_PCT
        || $past(meas_i.copper_thermal_image) > MSS_COPPER_PREALARM_PCT; endproperty
    a_lo1_cause: assert property (p_lo1_cause) else $error("first output rose without cause");
    property p_input_sync; req_o.local_ctrl || req_o.freewheel_stop |-> $past(logic_input_i, 3); endproperty
    a_input_sync: assert property (p_input_sync) else $error("input acted before synchroniser");
    property p_blank; keypad_present_i |=> !display_blank_o; endproperty
    a_blank: assert property (p_blank) else $error("display blanked with keypad fitted");
    property p_preset; !$past(rst_i) && !$past(rst_i, 2) |-> $stable(preset_o) && preset_o.accel_ramp_time
        == (preset_o.heavy ? MSS_HVY_ACCEL_S : MSS_STD_ACCEL_S); endproperty
    a_preset: assert property (p_preset) else $error("preset set changed or mismatched");
    c_eos: cover property ($rose(outs_o.end_of_start_relay));
    c_oc: cover property ($rose(outs_o.overcurrent_logic_output));
    c_lo1: cover property ($rose(outs_o.first_logic_output));
endmodule
bind mss_io mss_io_checker #(.OC_DELAY_CYC(OC_DELAY_CYC)) u_checker (.clk_i, .rst_i,
    .core_i, .meas_i, .logic_input_i, .keypad_present_i,
    .outs_o, .req_o, .preset_o, .display_blank_o);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the starter signalling block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mss_pkg::*;
    localparam longint OC_CYC = 20;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, short_on;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic logic_input_i, duty_select_i, keypad_present_i, display_blank_o;
    mss_core_t core_i;
    mss_meas_t meas_i;
    mss_outs_t outs_o;
    mss_req_t req_o;
    mss_preset_t preset_o;
    logic [15:0] analog_status_output_o;
    logic [12:0] display_value_o;
    int miscompares, checked, n, m;
    int irn[6] = '{105, 106, 0, 0, 0, 0};
    int cop[6] = '{0, 0, 0, 0, 130, 131};
    int tf[6] = '{0, 0, 1, 0, 0, 0};
    int lo[6] = '{0, 1, 1, 0, 0, 1};
    int dsel[4] = '{1, 2, 4, 5};
    int dexp[4] = '{6000, 150, 120, 10};
    mss_io #(.OC_DELAY_CYC(OC_CYC)) u_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_i, .meas_i, .logic_input_i, .duty_select_i, .keypad_present_i,
        .outs_o, .req_o, .preset_o, .analog_status_output_o, .display_value_o, .display_blank_o);
    mss_contactor_model u_plant (.clk_i(clk_i), .outs_i(outs_o), .shorting_closed_o(short_on));
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic drive(input mss_core_t v);
        @(posedge clk_i);
        core_i <= v;
    endtask
    // Classic cycle: request held until ack is seen at a rising edge
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat, input logic [3:0] sel);
        @(posedge clk_i);
        wb_adr_i <= {24'h0, adr};
        wb_we_i <= we;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: no bus acknowledge", $time);
            test_done();
        end
    endtask
    task automatic cfg(input logic [31:0] v);
        wb(MSS_CFG_OFS, 1'b1, v, 4'hf);
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        wb(adr, 1'b0, 32'h0, 4'hf);
        chk(rd, exp);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Watchdog so any other hang still reaches the verdict; wb gives up on a stuck handshake after 16 cycles
    initial begin
        tick(6000);
        miscompares++;
        $display("Error at %0t: run timed out", $time);
        test_done();
    end
    initial begin
        {miscompares, checked, rst_i, wb_we_i, wb_cyc_i, wb_stb_i} = {32'd0, 32'd0, 4'h8};
        {wb_adr_i, wb_dat_i, wb_sel_i, core_i, meas_i} = '0;
        {logic_input_i, duty_select_i, keypad_present_i} = 3'b001;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        chk(outs_o, 4'h0);
        rdc(MSS_CFG_OFS, 32'h0);
        wb(8'h10, 1'b1, 32'hffff_ffff, 4'hf);
        rdc(8'h10, 32'h0);
        wb(MSS_CFG_OFS, 1'b1, 32'h0000_5001, 4'h1);
        rdc(MSS_CFG_OFS, 32'h1);
        wb(MSS_PRESET_OFS, 1'b1, 32'hffff_ffff, 4'hf);
        rdc(MSS_PRESET_OFS, {5'h0, 1'b0, MSS_STD_ACCEL_S, MSS_STD_ILIM_PCT, MSS_STD_OL_CLASS});
        cfg(32'h0);
        $display("Test registers done");
        drive('{diag_done: 1'b1, default: 1'b0});
        tick(2);
        chk(outs_o.fault_isolation_relay, 1'b1);
        // Full speed then fault, then full speed then stop
        for (int i = 0; i < 2; i++) begin
            drive('{diag_done: 1'b1, full_speed: 1'b1, default: 1'b0});
            tick(2);
            chk(outs_o.end_of_start_relay, 1'b1);
            tick(6);
            chk(short_on, 1'b1);
            drive(i ? 10'h220 : 10'h300);
            tick(2);
            chk(outs_o.end_of_start_relay, 1'b0);
            chk(short_on, 1'b0);
            chk(outs_o.fault_isolation_relay, i[0]);
        end
        cfg(32'h1);
        tick(2);
        chk(outs_o.fault_isolation_relay, 1'b0);
        drive('{run_cmd: 1'b1, default: 1'b0});
        drive('0);
        tick(2);
        chk(outs_o.fault_isolation_relay, 1'b1);
        drive('{decel_done: 1'b1, default: 1'b0});
        tick(2);
        chk(outs_o.fault_isolation_relay, 1'b0);
        cfg(32'h0);
        $display("Test relays done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            meas_i.iron_thermal_image <= irn[i][7:0];
            meas_i.copper_thermal_image <= cop[i][7:0];
            core_i.thermal_fault <= tf[i][0];
            tick(2);
            chk(outs_o.first_logic_output, lo[i]);
        end
        meas_i <= '0;
        cfg(32'h2);
        for (int i = 0; i < 2; i++) begin
            drive('{current_present: i[0], default: 1'b0});
            tick(2);
            chk(outs_o.first_logic_output, i);
        end
        $display("Test first output done");
        drive('{over_trip: 1'b1, default: 1'b0});
        tick(OC_CYC + 8);
        chk(outs_o.overcurrent_logic_output, 1'b0);
        cfg(32'h4);
        for (m = 0; m < OC_CYC + 8 && outs_o.overcurrent_logic_output !== 1'b1; m++)
            tick(1);
        chk(m >= OC_CYC - 1, 1'b1);
        chk(outs_o.overcurrent_logic_output, 1'b1);
        drive('0);
        tick(2);
        chk(outs_o.overcurrent_logic_output, 1'b0);
        $display("Test overcurrent done");
        // The four request input modes, each through the synchroniser and back
        for (int i = 0; i < 4; i++) begin
            cfg(i << MSS_CFG_LI_POS);
            @(posedge clk_i);
            logic_input_i <= 1'b1;
            tick(2);
            chk(req_o, 5'h0);
            tick(2);
            chk(req_o, 5'h10 >> i);
            @(posedge clk_i);
            logic_input_i <= 1'b0;
            tick(5);
            chk(req_o, 5'h0);
        end
        for (int i = 4; i < 6; i++) begin
            cfg(i << MSS_CFG_LI_POS);
            drive(i == 4 ? 10'h080 : 10'h100);
            drive('0);
            tick(2);
            chk(req_o.restart_block, 1'b1);
            @(posedge clk_i);
            logic_input_i <= 1'b1;
            tick(4);
            chk(req_o.restart_block, 1'b0);
            @(posedge clk_i);
            logic_input_i <= 1'b0;
        end
        $display("Test logic input done");
        meas_i <= '{current_a: 13'd6000, load_pct: 8'd200, thermal_pct: 8'd130, pf_centi: 8'd5, default: '0};
        drive('{accelerating: 1'b1, default: 1'b0});
        for (int i = 0; i < 4; i++) begin
            cfg(dsel[i] << MSS_CFG_DSP_POS);
            tick(2);
            chk(display_value_o, dexp[i]);
        end
        drive('0);
        cfg(32'h1000);
        tick(2);
        chk(display_value_o, 13'd0);
        drive('{fault: 1'b1, default: 1'b0});
        cfg(32'h0);
        tick(2);
        chk(display_value_o, MSS_ST_FAULT);
        drive('0);
        tick(2);
        chk(display_value_o, MSS_ST_READY);
        meas_i <= '0;
        for (int i = 0; i < 8; i++) begin
            cfg((i % 4) << MSS_CFG_ANS_POS | (i / 4) << MSS_CFG_ANR_POS);
            tick(2);
            chk(analog_status_output_o, i < 4 ? 16'h0 : MSS_AN_LIVE_ZERO);
        end
        $display("Test display done");
        keypad_present_i <= 1'b0;
        drive('{diag_done: 1'b1, default: 1'b0});
        tick(2);
        chk(display_blank_o, 1'b1);
        chk(outs_o.fault_isolation_relay, 1'b1);
        keypad_present_i <= 1'b1;
        duty_select_i <= 1'b1;
        tick(6);
        chk(preset_o.heavy, 1'b0);
        drive('0);
        rst_i <= 1'b1;
        tick(4);
        rst_i <= 1'b0;
        tick(3);
        chk(outs_o, 4'h0);
        rdc(MSS_PRESET_OFS, {5'h0, 1'b1, MSS_HVY_ACCEL_S, MSS_HVY_ILIM_PCT, MSS_HVY_OL_CLASS});
        $display("Test presets done");
        test_done();
    end
endmodule
`default_nettype wire

// ===== verilog/mss_io.sv
// Motor starter relay, logic output, logic input and display signalling
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module mss_io #(
    parameter longint OC_DELAY_CYC = mss_pkg::MSS_OC_DELAY_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire mss_pkg::mss_core_t core_i,
    input wire mss_pkg::mss_meas_t meas_i,
    input wire logic logic_input_i,
    input wire logic duty_select_i,
    input wire logic keypad_present_i,
    output mss_pkg::mss_outs_t outs_o,
    output mss_pkg::mss_req_t req_o,
    output mss_pkg::mss_preset_t preset_o,
    output logic [15:0] analog_status_output_o,
    output logic [12:0] display_value_o,
    output logic display_blank_o
);
    import mss_pkg::*;

    // Whole module state
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdat;
        logic ack;
        logic [1:0] li_sync;
        logic [1:0] duty_sync;
        logic preset_taken;
        mss_preset_t preset;
        logic iso_run;
        logic prealarm_hold;
        logic [39:0] oc_cnt;
        logic oc_alarm;
        logic restart_block;
        logic had_fault;
        logic had_therm;
        mss_outs_t outs;
        mss_req_t req;
        logic [15:0] analog;
        logic [12:0] disp;
        logic blank;
    } mss_state_t;

    mss_state_t state_reg;
    mss_state_t state_next;

    // Clamp an 8-bit percentage to a ceiling
    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] hi);
        clamp8 = (v > hi) ? hi : v;
    endfunction

    // Scale a value against its full scale onto the analog range
    function automatic logic [15:0] scale16(input logic [12:0] v, input logic [12:0] full, input logic live);
        logic [31:0] raw;
        logic [31:0] span;
        raw = 32'h0;
        span = live ? 32'(16'hffff - MSS_AN_LIVE_ZERO) : 32'h0000_ffff;
        raw = (32'(v) * span) / 32'(full);
        scale16 = live ? 16'(raw + 32'(MSS_AN_LIVE_ZERO)) : raw[15:0];
    endfunction

    wire logic li_active;
    wire logic prealarm;
    wire mss_relay_mode_t relay_mode;
    wire mss_lo_mode_t lo_mode;
    wire logic oc_enable;
    wire mss_an_range_t an_range;
    wire mss_an_src_t an_src;
    wire mss_li_mode_t li_mode;
    wire mss_dsp_sel_t dsp_sel;
    wire logic wb_hit;

    // Only the second stage of the synchroniser is read
    assign li_active = state_reg.li_sync[1];
    assign prealarm = (meas_i.iron_thermal_image > MSS_IRON_PREALARM_PCT)
        || (meas_i.copper_thermal_image > MSS_COPPER_PREALARM_PCT);
    assign relay_mode = mss_relay_mode_t'(state_reg.cfg[MSS_CFG_RELAY_POS]);
    assign lo_mode = mss_lo_mode_t'(state_reg.cfg[MSS_CFG_LO_POS]);
    assign oc_enable = state_reg.cfg[MSS_CFG_OC_EN_POS];
    assign an_range = mss_an_range_t'(state_reg.cfg[MSS_CFG_ANR_POS]);
    assign an_src = mss_an_src_t'(state_reg.cfg[MSS_CFG_ANS_POS +: 2]);
    assign li_mode = mss_li_mode_t'(state_reg.cfg[MSS_CFG_LI_POS +: 3]);
    assign dsp_sel = mss_dsp_sel_t'(state_reg.cfg[MSS_CFG_DSP_POS +: 3]);
    assign wb_hit = wb_cyc_i && wb_stb_i && !state_reg.ack;

    // Next-state logic for the whole block
    always_comb begin
        logic eff_fault;
        logic [12:0] cur;
        eff_fault = 1'b0;
        cur = 13'h0;
        state_next = state_reg;
        // Classic Wishbone slave, one wait cycle, ack dropped after one cycle
        state_next.ack = wb_hit;
        state_next.rdat = 32'h0;
        if (wb_hit) begin
            if (wb_we_i && wb_adr_i[7:0] == MSS_CFG_OFS) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        state_next.cfg[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end
            unique case (wb_adr_i[7:0])
                MSS_CFG_OFS: state_next.rdat = state_reg.cfg;
                MSS_STAT_OFS: state_next.rdat = {19'h0, state_reg.req, state_reg.restart_block,
                    state_reg.oc_alarm, state_reg.prealarm_hold, state_reg.iso_run, state_reg.outs};
                MSS_PRESET_OFS: state_next.rdat = {5'h0, state_reg.preset};
                MSS_DISP_OFS: state_next.rdat = {18'h0, state_reg.blank, state_reg.disp};
                default: state_next.rdat = 32'h0;
            endcase
        end
        // Two-stage synchronisers for pins
        state_next.li_sync = {state_reg.li_sync[0], logic_input_i};
        state_next.duty_sync = {state_reg.duty_sync[0], duty_select_i};
        // Duty selector caught once after reset; a later change needs a reset
        if (!state_reg.preset_taken) begin
            state_next.preset_taken = 1'b1;
            state_next.preset.heavy = state_reg.duty_sync[1];
            state_next.preset.accel_ramp_time = state_reg.duty_sync[1] ? MSS_HVY_ACCEL_S : MSS_STD_ACCEL_S;
            state_next.preset.current_limit_level = state_reg.duty_sync[1] ? MSS_HVY_ILIM_PCT : MSS_STD_ILIM_PCT;
            state_next.preset.overload_class = state_reg.duty_sync[1] ? MSS_HVY_OL_CLASS : MSS_STD_OL_CLASS;
        end
        // Input functions
        state_next.req = '0;
        unique case (li_mode)
            MSS_LI_FREEWHEEL: state_next.req.freewheel_stop = li_active;
            MSS_LI_EXT_FAULT: state_next.req.ext_fault = li_active;
            MSS_LI_LOCAL: state_next.req.local_ctrl = li_active;
            MSS_LI_CASCADE: state_next.req.cascade = li_active;
            MSS_LI_THERM_RESET, MSS_LI_FAULT_RESET: ;
            default: ;
        endcase
        eff_fault = core_i.fault || state_next.req.ext_fault;
        // Restart lockout: set by fault, released by input once fault clears
        if (core_i.thermal_fault) begin
            state_next.had_therm = 1'b1;
        end
        if (eff_fault) begin
            state_next.had_fault = 1'b1;
        end
        if (li_mode == MSS_LI_THERM_RESET) begin
            if (state_reg.had_therm && !core_i.thermal_fault && li_active) begin
                state_next.had_therm = 1'b0;
            end
            state_next.restart_block = state_next.had_therm;
        end else if (li_mode == MSS_LI_FAULT_RESET) begin
            if (state_reg.had_fault && !eff_fault && li_active) begin
                state_next.had_fault = 1'b0;
            end
            state_next.restart_block = state_next.had_fault;
        end else begin
            state_next.had_fault = 1'b0;
            state_next.had_therm = 1'b0;
            state_next.restart_block = 1'b0;
        end
        state_next.req.restart_block = state_next.restart_block;
        // Relay one: fault indication or isolation contactor
        if (relay_mode == MSS_RELAY_FAULT) begin
            state_next.iso_run = 1'b0;
            if (eff_fault) begin
                state_next.outs.fault_isolation_relay = 1'b0;
            end else if (core_i.diag_done) begin
                state_next.outs.fault_isolation_relay = 1'b1;
            end
        end else begin
            if (eff_fault || core_i.decel_done) begin
                state_next.iso_run = 1'b0;
            end else if (core_i.run_cmd && !state_reg.restart_block) begin
                state_next.iso_run = 1'b1;
            end
            state_next.outs.fault_isolation_relay = state_next.iso_run;
        end
        // End-of-start relay; fault and stop take priority over full speed
        if (eff_fault || core_i.stop_cmd) begin
            state_next.outs.end_of_start_relay = 1'b0;
        end else if (core_i.full_speed) begin
            state_next.outs.end_of_start_relay = 1'b1;
        end
        // Pre-alarm held until thermal fault gone; set wins over clear
        if (prealarm) begin
            state_next.prealarm_hold = 1'b1;
        end else if (!core_i.thermal_fault) begin
            state_next.prealarm_hold = 1'b0;
        end
        state_next.outs.first_logic_output = (lo_mode == MSS_LO_PREALARM)
            ? state_next.prealarm_hold : core_i.current_present;
        // Overcurrent persistence timer
        if (!oc_enable || !core_i.over_trip) begin
            state_next.oc_cnt = 40'h0;
            state_next.oc_alarm = 1'b0;
        end else if (state_reg.oc_cnt < 40'(OC_DELAY_CYC)) begin
            state_next.oc_cnt = state_reg.oc_cnt + 40'h1;
        end else begin
            state_next.oc_alarm = 1'b1;
        end
        state_next.outs.overcurrent_logic_output = oc_enable && state_next.oc_alarm;
        // Analog status output
        unique case (an_src)
            MSS_AN_CURRENT: state_next.analog = scale16(clamp13(meas_i.current_a), MSS_CURRENT_MAX_A,
                an_range == MSS_AN_4_20);
            MSS_AN_TORQUE: state_next.analog = scale16(13'(clamp8(meas_i.load_pct, MSS_LOAD_MAX_PCT)),
                13'(MSS_LOAD_MAX_PCT), an_range == MSS_AN_4_20);
            MSS_AN_THERMAL: state_next.analog = scale16(13'(clamp8(meas_i.thermal_pct, MSS_THERM_MAX_PCT)),
                13'(MSS_THERM_MAX_PCT), an_range == MSS_AN_4_20);
            MSS_AN_PF: state_next.analog = scale16(13'(clamp8(meas_i.pf_centi, MSS_PF_MAX_CENTI)),
                13'(MSS_PF_MAX_CENTI), an_range == MSS_AN_4_20);
        endcase
        // Display; keypad presence only gates blanking, never control
        cur = clamp13(meas_i.current_a);
        state_next.blank = !keypad_present_i;
        state_next.disp = 13'h0;
        unique case (dsp_sel)
            MSS_DSP_STATUS: state_next.disp = eff_fault ? 13'(MSS_ST_FAULT)
                : (core_i.run_cmd || core_i.accelerating || core_i.full_speed) ? 13'(MSS_ST_RUN)
                : 13'(MSS_ST_READY);
            MSS_DSP_CURRENT: state_next.disp = (core_i.accelerating || core_i.full_speed) ? cur : 13'h0;
            MSS_DSP_LOAD: state_next.disp = 13'(clamp8(meas_i.load_pct, MSS_LOAD_MAX_PCT));
            MSS_DSP_POWER: state_next.disp = 13'(meas_i.load_pct);
            MSS_DSP_THERMAL: state_next.disp = 13'(clamp8(meas_i.thermal_pct, MSS_THERM_MAX_PCT));
            MSS_DSP_PF: state_next.disp = (meas_i.pf_centi < MSS_PF_MIN_CENTI) ? 13'(MSS_PF_MIN_CENTI)
                : 13'(clamp8(meas_i.pf_centi, MSS_PF_MAX_CENTI));
            default: state_next.disp = 13'h0;
        endcase
    end

    // Current clamp to display ceiling
    function automatic logic [12:0] clamp13(input logic [12:0] v);
        clamp13 = (v > MSS_CURRENT_MAX_A) ? MSS_CURRENT_MAX_A : v;
    endfunction

    // State register; reset leaves every output de-energised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.cfg <= MSS_CFG_RESET;
            // Selector keeps settling through reset so the capture sees the pin
            state_reg.duty_sync <= state_next.duty_sync;
        end else begin
            state_reg <= state_next;
        end
    end

    assign outs_o = state_reg.outs;
    assign req_o = state_reg.req;
    assign preset_o = state_reg.preset;
    assign analog_status_output_o = state_reg.analog;
    assign display_value_o = state_reg.disp;
    assign display_blank_o = state_reg.blank;
    assign wb_dat_o = state_reg.rdat;
    assign wb_ack_o = state_reg.ack;
endmodule
`default_nettype wire

// ===== verilog/mss_pkg.sv
// Package for the motor starter I/O signalling block
package mss_pkg;

    // Relay function selections
    typedef enum logic {MSS_RELAY_FAULT, MSS_RELAY_ISO} mss_relay_mode_t;
    // First logic output function
    typedef enum logic {MSS_LO_PREALARM, MSS_LO_POWER} mss_lo_mode_t;
    // Logic input function
    typedef enum logic [2:0] {
        MSS_LI_FREEWHEEL, MSS_LI_EXT_FAULT, MSS_LI_LOCAL, MSS_LI_CASCADE,
        MSS_LI_THERM_RESET, MSS_LI_FAULT_RESET
    } mss_li_mode_t;
    // Analog output source and range
    typedef enum logic [1:0] {MSS_AN_CURRENT, MSS_AN_TORQUE, MSS_AN_THERMAL, MSS_AN_PF} mss_an_src_t;
    typedef enum logic {MSS_AN_0_20, MSS_AN_4_20} mss_an_range_t;
    // Display selection
    typedef enum logic [2:0] {
        MSS_DSP_STATUS, MSS_DSP_CURRENT, MSS_DSP_LOAD, MSS_DSP_POWER, MSS_DSP_THERMAL, MSS_DSP_PF
    } mss_dsp_sel_t;
    // Status code shown in status display mode
    typedef enum logic [1:0] {MSS_ST_READY, MSS_ST_RUN, MSS_ST_FAULT} mss_status_t;

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] MSS_CFG_OFS = 8'h00;
    localparam logic [7:0] MSS_STAT_OFS = 8'h04;
    localparam logic [7:0] MSS_PRESET_OFS = 8'h08;
    localparam logic [7:0] MSS_DISP_OFS = 8'h0c;
    // Configuration field positions
    localparam int MSS_CFG_RELAY_POS = 0;
    localparam int MSS_CFG_LO_POS = 1;
    localparam int MSS_CFG_OC_EN_POS = 2;
    localparam int MSS_CFG_ANR_POS = 3;
    localparam int MSS_CFG_ANS_POS = 4;
    localparam int MSS_CFG_LI_POS = 8;
    localparam int MSS_CFG_DSP_POS = 12;
    localparam logic [31:0] MSS_CFG_RESET = 32'h0000_0000;

    // Thermal thresholds in percent
    localparam logic [7:0] MSS_IRON_PREALARM_PCT = 8'd105;
    localparam logic [7:0] MSS_COPPER_PREALARM_PCT = 8'd130;
    // Display clamps
    localparam logic [12:0] MSS_CURRENT_MAX_A = 13'd6000;
    localparam logic [7:0] MSS_LOAD_MAX_PCT = 8'd150;
    localparam logic [7:0] MSS_THERM_MAX_PCT = 8'd120;
    localparam logic [7:0] MSS_PF_MIN_CENTI = 8'd10;
    localparam logic [7:0] MSS_PF_MAX_CENTI = 8'd100;
    // 4-20 mA offset is 4/20 of full scale on a 16-bit code
    localparam logic [15:0] MSS_AN_LIVE_ZERO = 16'h3333;

    // Duty presets
    localparam logic [7:0] MSS_STD_ACCEL_S = 8'd10;
    localparam logic [7:0] MSS_HVY_ACCEL_S = 8'd15;
    localparam logic [9:0] MSS_STD_ILIM_PCT = 10'd300;
    localparam logic [9:0] MSS_HVY_ILIM_PCT = 10'd350;
    localparam logic [7:0] MSS_STD_OL_CLASS = 8'd10;
    localparam logic [7:0] MSS_HVY_OL_CLASS = 8'd20;

    // Overcurrent alarm delay
    localparam int MSS_OC_DELAY_MS = 10000;
    localparam int MSS_CLK_HZ = 100_000_000;
    localparam longint MSS_OC_DELAY_CYC = longint'(MSS_OC_DELAY_MS) * MSS_CLK_HZ / 1000;

    // Monitored process values from the motor-control core
    typedef struct packed {
        logic [12:0] current_a;
        logic [7:0] load_pct;
        logic [7:0] thermal_pct;
        logic [7:0] pf_centi;
        logic [7:0] iron_thermal_image;
        logic [7:0] copper_thermal_image;
    } mss_meas_t;

    // Control events from the motor-control core
    typedef struct packed {
        logic diag_done;
        logic fault;
        logic thermal_fault;
        logic run_cmd;
        logic stop_cmd;
        logic decel_done;
        logic full_speed;
        logic accelerating;
        logic current_present;
        logic over_trip;
    } mss_core_t;

    // Relay and logic outputs
    typedef struct packed {
        logic fault_isolation_relay;
        logic end_of_start_relay;
        logic first_logic_output;
        logic overcurrent_logic_output;
    } mss_outs_t;

    // Duty preset set
    typedef struct packed {
        logic heavy;
        logic [7:0] accel_ramp_time;
        logic [9:0] current_limit_level;
        logic [7:0] overload_class;
    } mss_preset_t;

    // Requests to the motor-control core
    typedef struct packed {
        logic freewheel_stop;
        logic ext_fault;
        logic local_ctrl;
        logic cascade;
        logic restart_block;
    } mss_req_t;

endpackage
